// File: verilog/krpm_keypad_row_pin_mux.sv
// Purpose: Pin multiplexer for two keypad row-sense pads (pad A and pad B).
// Assumes: Pad inputs are asynchronous and pass two flip-flops; inner signals are on mclk.
// Notes: Pad output enables are active low; pulls are dropped whenever a pad drives.
// Functional notes
// - With set select low, each pad can feed a keypad row sense.
// - Pad A codec frame sync serves both directions sync, transmitter only async.
// - While pad A carries codec frame sync, primary frame-sync pad is disabled.
// - Pad A as general-purpose output drives port A carrier detect.
// - After reset both pads are general-purpose inputs.
// - With set select high, pad A is debug-event; external converter requests debug.
// - On debug entry, assert debug-event output for three clock cycles.
// - Debug-event pad is open drain: pulls low or releases.
// - While pad A is debug-event, primary debug-event pad is disabled.
// - Pad B codec bit clock serves both directions sync, transmitter only async.
// - While pad B carries codec bit clock, primary codec clock pad is disabled.
// - Pad B as general-purpose output drives port A ring indicator.
// - With set select high, pad B supplies test clock to the TAP controller.
// - While pad B supplies test clock, primary test-clock pad is disconnected.
// - A pad driven as output has its pull resistor disconnected.
`timescale 1ns/1ps
module krpm_keypad_row_pin_mux (
	input wire logic mclk,
	input wire logic rst,
	input wire logic pin_function_set_select,
	input wire logic [1:0] fn_sel_a,
	input wire logic [1:0] fn_sel_b,
	input wire krpm_pkg::krpm_gpio_t gpio_a,
	input wire krpm_pkg::krpm_gpio_t gpio_b,
	input wire logic pad_a_in,
	output logic pad_a_out,
	output logic pad_a_oe_n,
	output logic pad_a_pull_en,
	input wire logic pad_b_in,
	output logic pad_b_out,
	output logic pad_b_oe_n,
	output logic pad_b_pull_en,
	output logic keypad_row_sense_a,
	output logic keypad_row_sense_b,
	output logic general_purpose_input_a,
	output logic general_purpose_input_b,
	input wire logic codec_sync_mode,
	input wire logic codec_frame_sync_out,
	input wire logic codec_frame_sync_dir_out,
	output logic codec_frame_sync_alt_tx,
	output logic codec_frame_sync_alt_rx,
	output logic codec_primary_frame_sync_dis,
	input wire logic codec_bit_clock_out,
	input wire logic codec_bit_clock_dir_out,
	output logic codec_bit_clock_alt_tx,
	output logic codec_bit_clock_alt_rx,
	output logic codec_primary_bit_clock_dis,
	output logic port_a_carrier_detect,
	output logic port_a_ring_indicator,
	input wire logic debug_entry,
	output logic signal_processor_debug_event,
	output logic primary_debug_event_dis,
	output logic tap_test_clock,
	output logic primary_test_clock_dis
);

	// ==========================================================
	// Helpers
	// ==========================================================
	// An unknown select code falls back to GPIO.
	function automatic krpm_pkg::krpm_fn_t decode_fn(input logic [1:0] code);
		krpm_pkg::krpm_fn_t f;
		f = krpm_pkg::KRPM_FN_GPIO;
		if (code == 2'h1) begin
			f = krpm_pkg::KRPM_FN_ROW;
		end else if (code == 2'h2) begin
			f = krpm_pkg::KRPM_FN_CODEC;
		end
		return f;
	endfunction

	// ==========================================================
	// Pad input synchronisers
	// ==========================================================
	logic [1:0] sync1_reg;
	logic [1:0] sync2_reg;
	logic [1:0] sync1_next;
	logic [1:0] sync2_next;

	always_comb begin
		sync1_next = {pad_b_in, pad_a_in};
		sync2_next = sync1_reg;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sync1_reg <= 2'h3;
			sync2_reg <= 2'h3;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
		end
	end

	logic pa_in;
	logic pb_in;
	assign pa_in = sync2_reg[0];
	assign pb_in = sync2_reg[1];

	// ==========================================================
	// Function selection
	// ==========================================================
	krpm_pkg::krpm_fn_t fn_a;
	krpm_pkg::krpm_fn_t fn_b;
	logic alt_set;
	assign fn_a = decode_fn(fn_sel_a);
	assign fn_b = decode_fn(fn_sel_b);
	assign alt_set = pin_function_set_select;

	logic a_row;
	logic a_codec;
	logic a_gpio;
	logic b_row;
	logic b_codec;
	logic b_gpio;
	assign a_row = !alt_set && (fn_a == krpm_pkg::KRPM_FN_ROW);
	assign a_codec = !alt_set && (fn_a == krpm_pkg::KRPM_FN_CODEC);
	assign a_gpio = !alt_set && (fn_a == krpm_pkg::KRPM_FN_GPIO);
	assign b_row = !alt_set && (fn_b == krpm_pkg::KRPM_FN_ROW);
	assign b_codec = !alt_set && (fn_b == krpm_pkg::KRPM_FN_CODEC);
	assign b_gpio = !alt_set && (fn_b == krpm_pkg::KRPM_FN_GPIO);

	// ==========================================================
	// Debug-event pulse
	// ==========================================================
	logic [1:0] dbg_cnt_reg;
	logic [1:0] dbg_cnt_next;
	logic dbg_entry_d_reg;
	logic dbg_entry_d_next;
	logic dbg_pulse;

	always_comb begin
		dbg_entry_d_next = debug_entry;
		dbg_cnt_next = dbg_cnt_reg;
		if (alt_set && debug_entry && !dbg_entry_d_reg) begin
			dbg_cnt_next = krpm_pkg::KRPM_DEBUG_PULSE_CYCLES;
		end else if (dbg_cnt_reg != 2'h0) begin
			dbg_cnt_next = dbg_cnt_reg - 2'h1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			dbg_cnt_reg <= 2'h0;
			dbg_entry_d_reg <= 1'b0;
		end else begin
			dbg_cnt_reg <= dbg_cnt_next;
			dbg_entry_d_reg <= dbg_entry_d_next;
		end
	end

	assign dbg_pulse = alt_set && (dbg_cnt_reg != 2'h0);

	// ==========================================================
	// Pad drive
	// ==========================================================
	krpm_pkg::krpm_pad_t pa_reg;
	krpm_pkg::krpm_pad_t pa_next;
	krpm_pkg::krpm_pad_t pb_reg;
	krpm_pkg::krpm_pad_t pb_next;

	always_comb begin
		pa_next = '{din: 1'b0, dout: 1'b0, oe_n: 1'b1, pull_en: 1'b1};
		if (alt_set) begin
			pa_next.dout = 1'b0;
			pa_next.oe_n = !dbg_pulse;
		end else if (a_codec && codec_frame_sync_dir_out) begin
			pa_next.dout = codec_frame_sync_out;
			pa_next.oe_n = 1'b0;
		end else if (a_gpio && gpio_a.gp_dir_out) begin
			pa_next.dout = gpio_a.gp_out;
			pa_next.oe_n = 1'b0;
		end
		pa_next.pull_en = pa_next.oe_n;
		pb_next = '{din: 1'b0, dout: 1'b0, oe_n: 1'b1, pull_en: 1'b1};
		if (b_codec && codec_bit_clock_dir_out) begin
			pb_next.dout = codec_bit_clock_out;
			pb_next.oe_n = 1'b0;
		end else if (b_gpio && gpio_b.gp_dir_out) begin
			pb_next.dout = gpio_b.gp_out;
			pb_next.oe_n = 1'b0;
		end
		pb_next.pull_en = pb_next.oe_n;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pa_reg <= '{din: 1'b0, dout: 1'b0, oe_n: 1'b1, pull_en: 1'b1};
			pb_reg <= '{din: 1'b0, dout: 1'b0, oe_n: 1'b1, pull_en: 1'b1};
		end else begin
			pa_reg <= pa_next;
			pb_reg <= pb_next;
		end
	end

	assign pad_a_out = pa_reg.dout;
	assign pad_a_oe_n = pa_reg.oe_n;
	assign pad_a_pull_en = pa_reg.pull_en;
	assign pad_b_out = pb_reg.dout;
	assign pad_b_oe_n = pb_reg.oe_n;
	assign pad_b_pull_en = pb_reg.pull_en;

	// ==========================================================
	// Inward routing to the keypad and GPIO
	// ==========================================================
	// Inactive row senses read high, as an idle pulled-up row.
	// This keeps the keypad scanner from seeing a phantom key on a pad lent elsewhere.
	always_comb begin
		keypad_row_sense_a = 1'b1;
		keypad_row_sense_b = 1'b1;
		general_purpose_input_a = 1'b0;
		general_purpose_input_b = 1'b0;
		if (a_row) begin
			keypad_row_sense_a = pa_in;
		end
		if (b_row) begin
			keypad_row_sense_b = pb_in;
		end
		if (a_gpio) begin
			general_purpose_input_a = pa_in;
		end
		if (b_gpio) begin
			general_purpose_input_b = pb_in;
		end
	end

	// ==========================================================
	// Inward routing to the audio codec
	// ==========================================================
	// Receiver paths get the alternate pad only in synchronous mode.
	// In asynchronous mode the receiver keeps its own timing source.
	always_comb begin
		codec_frame_sync_alt_tx = 1'b0;
		codec_frame_sync_alt_rx = 1'b0;
		codec_bit_clock_alt_tx = 1'b0;
		codec_bit_clock_alt_rx = 1'b0;
		if (a_codec) begin
			codec_frame_sync_alt_tx = pa_in;
			if (codec_sync_mode) begin
				codec_frame_sync_alt_rx = pa_in;
			end
		end
		if (b_codec) begin
			codec_bit_clock_alt_tx = pb_in;
			if (codec_sync_mode) begin
				codec_bit_clock_alt_rx = pb_in;
			end
		end
	end

	// The primary codec pads are shut off so two pads never fight for one signal.
	always_comb begin
		codec_primary_frame_sync_dis = 1'b0;
		codec_primary_bit_clock_dis = 1'b0;
		if (a_codec) begin
			codec_primary_frame_sync_dis = 1'b1;
		end
		if (b_codec) begin
			codec_primary_bit_clock_dis = 1'b1;
		end
	end

	// ==========================================================
	// Modem status lines
	// ==========================================================
	// The status lines follow the level that software drives onto the pad.
	always_comb begin
		port_a_carrier_detect = 1'b0;
		port_a_ring_indicator = 1'b0;
		if (a_gpio && gpio_a.gp_dir_out) begin
			port_a_carrier_detect = gpio_a.gp_out;
		end
		if (b_gpio && gpio_b.gp_dir_out) begin
			port_a_ring_indicator = gpio_b.gp_out;
		end
	end

	// ==========================================================
	// Debug and test-clock routing
	// ==========================================================
	// Debug request is active low; idle reads high.
	// The test clock idles high so the TAP controller sees no stray edge.
	always_comb begin
		signal_processor_debug_event = 1'b1;
		primary_debug_event_dis = 1'b0;
		tap_test_clock = 1'b1;
		primary_test_clock_dis = 1'b0;
		if (alt_set) begin
			signal_processor_debug_event = pa_in;
			primary_debug_event_dis = 1'b1;
			tap_test_clock = pb_in;
			primary_test_clock_dis = 1'b1;
		end
	end

endmodule

// File: common/krpm_pkg.sv
// Purpose: Shared types and constants for the keypad row pin multiplexer.
// Assumes: One clock domain, mclk at 200 MHz.
// Notes: Function-select codes are plain inputs; there is no register bus.
package krpm_pkg;

	// ==========================================================
	// Function selection
	// ==========================================================
	typedef enum logic [1:0] {
		KRPM_FN_GPIO = 2'h0,
		KRPM_FN_ROW = 2'h1,
		KRPM_FN_CODEC = 2'h2
	} krpm_fn_t;

	localparam krpm_fn_t KRPM_FN_RESET = KRPM_FN_GPIO;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int KRPM_CLK_MHZ = 200;
	localparam logic [1:0] KRPM_DEBUG_PULSE_CYCLES = 2'h3;

	// ==========================================================
	// Pad carriers
	// ==========================================================
	typedef struct packed {
		logic din;
		logic dout;
		logic oe_n;
		logic pull_en;
	} krpm_pad_t;

	typedef struct packed {
		logic gp_out;
		logic gp_dir_out;
	} krpm_gpio_t;

endpackage

// File: bench/krpm_checker.sv
// Purpose: Port checks for the keypad row pin mux.
// Assumes: One clock domain, rst asynchronous and active high.
// Notes: Bound to every mux instance.
`timescale 1ns/1ps
module krpm_checker (
	input wire logic mclk,
	input wire logic rst,
	input wire logic pin_function_set_select,
	input wire logic [1:0] fn_sel_a,
	input wire krpm_pkg::krpm_gpio_t gpio_a,
	input wire logic pad_a_out,
	input wire logic pad_a_oe_n,
	input wire logic pad_a_pull_en,
	input wire logic pad_b_in,
	input wire logic pad_b_oe_n,
	input wire logic codec_primary_frame_sync_dis,
	input wire logic port_a_carrier_detect,
	input wire logic debug_entry,
	input wire logic primary_debug_event_dis,
	input wire logic tap_test_clock
);
	// ========================================
	// Checks
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic sel;
	assign sel = pin_function_set_select;
	a_pull_drop: assert property (pad_a_pull_en == pad_a_oe_n)
		else $error("pull left on");
	a_debug_pulse: assert property ($rose(debug_entry) && sel && pad_a_oe_n
		|-> ##2 !pad_a_oe_n [*3] ##1 pad_a_oe_n) else $error("bad pulse");
	a_open_drain: assert property (sel && $past(sel) && !pad_a_oe_n |-> !pad_a_out)
		else $error("debug pad driven high");
	a_b_input: assert property (sel && $past(sel) |-> pad_b_oe_n)
		else $error("pad b driven");
	a_tap_clock: assert property (sel && $past(sel) && $past(sel, 2)
		|-> tap_test_clock == $past(pad_b_in, 2)) else $error("test clock");
	a_debug_dis: assert property (primary_debug_event_dis == sel)
		else $error("debug pad select");
	a_frame_dis: assert property (codec_primary_frame_sync_dis == (!sel && fn_sel_a == 2'h2))
		else $error("frame sync select");
	a_carrier: assert property (!sel && fn_sel_a == 2'h0
		|-> port_a_carrier_detect == (gpio_a.gp_dir_out && gpio_a.gp_out)) else $error("carrier");
	c_pulse: cover property ($rose(debug_entry) && sel);
	c_codec: cover property (codec_primary_frame_sync_dis);
	c_drive: cover property (!sel && !pad_a_oe_n);
endmodule
bind krpm_keypad_row_pin_mux krpm_checker i_chk (.*);

// File: bench/krpm_partner.sv
// Purpose: Keypad, codec and debug converter beside the two pads.
// Assumes: The bench says when the far side drives and what level.
// Notes: A released pad follows its pull, else flips each cycle.
`timescale 1ns/1ps
module krpm_partner (
	input wire logic mclk,
	input wire krpm_pkg::krpm_gpio_t ext_a,
	input wire krpm_pkg::krpm_gpio_t ext_b,
	input wire logic pad_a_out,
	input wire logic pad_a_oe_n,
	input wire logic pad_a_pull_en,
	input wire logic pad_b_out,
	input wire logic pad_b_oe_n,
	input wire logic pad_b_pull_en,
	output logic pad_a_in,
	output logic pad_b_in
);
	// ========================================
	// Pad levels
	logic last_a, last_b;
	assign pad_a_in = !pad_a_oe_n ? pad_a_out : ext_a.gp_dir_out ? ext_a.gp_out
		: pad_a_pull_en ? 1'b1 : ~last_a;
	assign pad_b_in = !pad_b_oe_n ? pad_b_out : ext_b.gp_dir_out ? ext_b.gp_out
		: pad_b_pull_en ? 1'b1 : ~last_b;
	always_ff @(posedge mclk) begin
		last_a <= pad_a_in;
		last_b <= pad_b_in;
	end
endmodule

// File: bench/krpm_keypad_row_pin_mux_tb.sv
// Purpose: Scenario bench for the keypad row pin mux.
// Assumes: Inputs change at the falling edge of mclk.
// Notes: ext_a and ext_b carry far-side level and drive enable.
`timescale 1ns/1ps
module krpm_keypad_row_pin_mux_tb;
	logic mclk, pad_a_in, pad_a_out, pad_a_oe_n, pad_a_pull_en, pad_b_in, pad_b_out, pad_b_oe_n;
	logic pad_b_pull_en, keypad_row_sense_a, keypad_row_sense_b, general_purpose_input_a;
	logic general_purpose_input_b, codec_frame_sync_alt_tx, codec_frame_sync_alt_rx;
	logic codec_primary_frame_sync_dis, codec_bit_clock_alt_tx, codec_bit_clock_alt_rx;
	logic codec_primary_bit_clock_dis, port_a_carrier_detect, port_a_ring_indicator;
	logic signal_processor_debug_event, primary_debug_event_dis, tap_test_clock;
	logic primary_test_clock_dis, rst = 1'b1, pin_function_set_select = 1'b0, debug_entry = 1'b0;
	logic codec_sync_mode = 1'b0, codec_frame_sync_out = 1'b0, codec_frame_sync_dir_out = 1'b0;
	logic codec_bit_clock_out = 1'b0, codec_bit_clock_dir_out = 1'b0;
	logic [1:0] fn_sel_a = 2'h0, fn_sel_b = 2'h0;
	krpm_pkg::krpm_gpio_t gpio_a = 2'h0, gpio_b = 2'h0, ext_a = 2'h0, ext_b = 2'h0;
	int n_errors = 0, n_compared = 0;
	krpm_keypad_row_pin_mux i_dut (.*);
	krpm_partner i_far (.*);
	// ========================================
	// Shared tasks
	task automatic chk(input string what, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic close_out;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic count_low(input int exp);
		int n;
		n = 0;
		debug_entry = 1'b1;
		for (int i = 0; i < 8; i++) begin
			tick(1);
			n += (pad_a_oe_n === 1'b0);
		end
		debug_entry = 1'b0;
		chk("pulse_len", 1'b1, n == exp);
	endtask
	// ========================================
	// Scenarios
	task automatic t_reset;
		tick(2);
		chk("a_oe_n", 1'b1, pad_a_oe_n);
		chk("b_oe_n", 1'b1, pad_b_oe_n);
		rst = 1'b0;
		ext_a = 2'h3;
		tick(3);
		chk("gpi_a", 1'b1, general_purpose_input_a);
	endtask
	task automatic t_row;
		fn_sel_a = 2'h1;
		fn_sel_b = 2'h1;
		for (int v = 0; v < 2; v++) begin
			ext_a = {v[0], 1'b1};
			ext_b = {~v[0], 1'b1};
			tick(3);
			chk("row_a", v[0], keypad_row_sense_a);
			chk("row_b", ~v[0], keypad_row_sense_b);
			chk("gpi_a", 1'b0, general_purpose_input_a);
		end
	endtask
	task automatic t_gpio;
		fn_sel_a = 2'h0;
		fn_sel_b = 2'h3;
		ext_a = 2'h0;
		ext_b = 2'h0;
		gpio_a = 2'h3;
		gpio_b = 2'h3;
		tick(2);
		chk("b_pull_en", 1'b0, pad_b_pull_en);
		chk("carrier", 1'b1, port_a_carrier_detect);
		chk("ring", 1'b1, port_a_ring_indicator);
		gpio_a = 2'h2;
		gpio_b = 2'h0;
		tick(2);
		chk("carrier", 1'b0, port_a_carrier_detect);
		chk("gpi_b", 1'b1, general_purpose_input_b);
	endtask
	task automatic t_codec;
		fn_sel_a = 2'h2;
		fn_sel_b = 2'h2;
		ext_a = 2'h3;
		ext_b = 2'h3;
		for (int m = 0; m < 2; m++) begin
			codec_sync_mode = m[0];
			tick(3);
			chk("fs_rx", m[0], codec_frame_sync_alt_rx);
			chk("fs_tx", 1'b1, codec_frame_sync_alt_tx);
			chk("fs_dis", 1'b1, codec_primary_frame_sync_dis);
			chk("ck_tx", 1'b1, codec_bit_clock_alt_tx);
			chk("ck_rx", m[0], codec_bit_clock_alt_rx);
			chk("ck_dis", 1'b1, codec_primary_bit_clock_dis);
		end
		ext_a = 2'h0;
		ext_b = 2'h0;
		codec_frame_sync_dir_out = 1'b1;
		codec_frame_sync_out = 1'b1;
		codec_bit_clock_dir_out = 1'b1;
		codec_bit_clock_out = 1'b1;
		tick(2);
		chk("b_out", 1'b1, pad_b_out);
		chk("a_out", 1'b1, pad_a_out);
		chk("a_pull_en", 1'b0, pad_a_pull_en);
		codec_frame_sync_dir_out = 1'b0;
		codec_bit_clock_dir_out = 1'b0;
	endtask
	task automatic t_alt;
		count_low(0);
		pin_function_set_select = 1'b1;
		ext_a = 2'h1;
		ext_b = 2'h1;
		tick(3);
		chk("debug_in", 1'b0, signal_processor_debug_event);
		chk("tck_dis", 1'b1, primary_test_clock_dis);
		chk("de_dis", 1'b1, primary_debug_event_dis);
		chk("tck", 1'b0, tap_test_clock);
		ext_a = 2'h0;
		count_low(3);
	endtask
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	initial begin
		t_reset;
		t_row;
		t_gpio;
		t_codec;
		t_alt;
		close_out;
	end
endmodule
